// >>> rtl/fpec_flash_ctrl.sv
// Flash program/erase control with AXI4-Lite register access
//
// Design decisions made here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "fpec_regs.svh"
// Notes on behaviour
// - Busy flash toggles between paired reads
// - Mode 0y101 plus 0xD5 enables commands
// - Mode 0y010, area 0y00 disables, restores
// - 0x40 disables; 0xA0 or area enables
// - Both bits set plus 0xD4 maps RAM
// - Both bits clear plus 0xD4 unmaps
// - Vectors at 0x01F8 and 0x01FC in RAM
// - 0x10 to system control two resets
module fpec_flash_ctrl #(
  parameter int ERASE_CYCLES = 64,
  parameter int PROG_CYCLES = 16
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [11:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [11:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic ram_code_allocate_out,
  output logic vector_in_ram_out,
  output logic sys_clock_reset_out,
  output logic flash_busy_out
);
  // Live and staged settings
  logic [7:0] flash_control_one_r;
  fpec_pkg::fpec_flash_cfg_t cfg_r;
  logic [7:0] system_control_three_r;
  fpec_pkg::fpec_map_t map_r;
  fpec_pkg::fpec_state_t state_r;
  logic [2:0] seq_cnt_r;
  logic [15:0] cmd_addr_r;
  logic [15:0] busy_cnt_r;
  logic [1:0] gap_cnt_r;
  logic toggle_r;
  logic seq_err_r;
  logic is_erase_r;
  logic [7:0] read_data_r;
  logic [15:0] vec_sel_r;
  logic sys_reset_r;
  // AXI write channel holding
  logic aw_held_r;
  logic w_held_r;
  logic [11:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic awready_r;
  logic wready_r;
  logic arready_r;

  wire aw_take = s_axi_awvalid_in && !aw_held_r && !bvalid_r;
  wire w_take = s_axi_wvalid_in && !w_held_r && !bvalid_r;
  wire [11:0] wr_addr = aw_held_r ? awaddr_r : s_axi_awaddr_in;
  wire [31:0] wr_data = w_held_r ? wdata_r : s_axi_wdata_in;
  wire [3:0] wr_strb = w_held_r ? wstrb_r : s_axi_wstrb_in;
  wire aw_ok = aw_held_r || aw_take;
  wire w_ok = w_held_r || w_take;
  wire wr_fire = aw_ok && w_ok && !bvalid_r;
  wire wr_lane0 = wr_fire && wr_strb[0];
  wire [7:0] wbyte = wr_data[7:0];

  wire hit_c1 = wr_addr == `FPEC_OFF_FLASH_CTRL1;
  wire hit_c2 = wr_addr == `FPEC_OFF_FLASH_CTRL2;
  wire hit_s2 = wr_addr == `FPEC_OFF_SYS_CTRL2;
  wire hit_s3 = wr_addr == `FPEC_OFF_SYS_CTRL3;
  wire hit_s4 = wr_addr == `FPEC_OFF_SYS_CTRL4;
  wire hit_ca = wr_addr == `FPEC_OFF_CMD_ADDR;
  wire hit_cd = wr_addr == `FPEC_OFF_CMD_DATA;
  wire hit_vs = wr_addr == `FPEC_OFF_VEC_SEL;
  wire wr_mapped = hit_c1 | hit_c2 | hit_s2 | hit_s3 | hit_s4 | hit_ca |
    hit_cd | hit_vs;

  wire [2:0] stage_mode = flash_control_one_r[`FPEC_MODE_LSB +: 3];
  wire [1:0] stage_area = flash_control_one_r[`FPEC_AREA_LSB +: 2];
  wire stage_bank = flash_control_one_r[`FPEC_BANK_BIT];
  wire cmd_enabled = cfg_r.mode == `FPEC_MODE_ENABLE;
  wire flash_code = wr_lane0 && hit_c2 && wbyte == `FPEC_FLASH_EN_CODE;
  wire sys_code = wr_lane0 && hit_s4 && wbyte == `FPEC_SYS_EN_CODE;
  wire ram_bit = system_control_three_r[`FPEC_RAM_CODE_BIT];
  wire vec_bit = system_control_three_r[`FPEC_VEC_RAM_BIT];
  // A write to the command port counts as a flash bus write cycle
  wire cmd_wr = wr_lane0 && hit_cd;
  // Writes too close together break the sequence
  wire cmd_too_soon = gap_cnt_r != 2'h0;
  wire cmd_accept = cmd_wr && cmd_enabled && !cmd_too_soon;
  wire cmd_final_erase = cmd_accept && seq_cnt_r == `FPEC_ERASE_LAST &&
    wbyte == `FPEC_SECTOR_CMD;
  wire cmd_final_prog = cmd_accept && seq_cnt_r == `FPEC_PROG_LAST &&
    is_erase_r == 1'b0;
  wire is_busy = state_r == fpec_pkg::FPEC_BUSY;
  wire [15:0] vec_addr = vector_in_ram_out ? vec_sel_r : 16'h0000;

  // Read mux; busy flash toggles between reads of the same address
  wire rd_hit_data = s_axi_araddr_in == `FPEC_OFF_READ_DATA;
  wire [7:0] rd_flash = is_busy ? {1'b0, toggle_r, 6'h00} :
    read_data_r;
  // Live area and bank in bits 7:5 so the applied copy can be seen
  wire [31:0] status_word = {8'h00, vec_addr, cfg_r.area, cfg_r.bank,
    seq_err_r, map_r.ram_code, map_r.vec_ram, cmd_enabled, is_busy};
  wire rd_take = s_axi_arvalid_in && !rvalid_r;
  logic [31:0] rd_word;
  logic rd_ok;
  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_ok = 1'b1;
    unique case (s_axi_araddr_in)
      `FPEC_OFF_FLASH_CTRL1: rd_word = {24'h00_0000, flash_control_one_r};
      `FPEC_OFF_FLASH_CTRL2: rd_word = 32'h0000_0000;
      `FPEC_OFF_SYS_CTRL2: rd_word = 32'h0000_0000;
      `FPEC_OFF_SYS_CTRL3: rd_word = {24'h00_0000, system_control_three_r};
      `FPEC_OFF_SYS_CTRL4: rd_word = 32'h0000_0000;
      `FPEC_OFF_STATUS: rd_word = status_word;
      `FPEC_OFF_CMD_ADDR: rd_word = {16'h0000, cmd_addr_r};
      `FPEC_OFF_CMD_DATA: rd_word = 32'h0000_0000;
      `FPEC_OFF_READ_DATA: rd_word = {24'h00_0000, rd_flash};
      `FPEC_OFF_VEC_SEL: rd_word = {16'h0000, vec_sel_r};
      default: rd_ok = 1'b0;
    endcase
  end

  // AXI bookkeeping
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 12'h000;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= `FPEC_RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `FPEC_RESP_OKAY;
    end
    else
    begin
      if (wr_fire)
      begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_mapped ? `FPEC_RESP_OKAY : `FPEC_RESP_SLVERR;
      end
      else
      begin
        if (aw_take)
        begin
          aw_held_r <= 1'b1;
          awaddr_r <= s_axi_awaddr_in;
        end
        if (w_take)
        begin
          w_held_r <= 1'b1;
          wdata_r <= s_axi_wdata_in;
          wstrb_r <= s_axi_wstrb_in;
        end
        if (bvalid_r && s_axi_bready_in)
          bvalid_r <= 1'b0;
      end
      if (rd_take)
      begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_word;
        rresp_r <= rd_ok ? `FPEC_RESP_OKAY : `FPEC_RESP_SLVERR;
      end
      else if (rvalid_r && s_axi_rready_in)
        rvalid_r <= 1'b0;
    end
  end

  // Busy reads toggle on every read of the data port
  wire rd_data_take = rd_take && rd_hit_data;

  // Control registers and sequencer
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      flash_control_one_r <= `FPEC_CTRL1_RESET;
      cfg_r <= '{mode: `FPEC_MODE_DISABLE, area: `FPEC_AREA_INIT,
        bank: 1'b0};
      system_control_three_r <= 8'h00;
      map_r <= '{ram_code: 1'b0, vec_ram: 1'b0};
      state_r <= fpec_pkg::FPEC_IDLE;
      seq_cnt_r <= 3'h0;
      cmd_addr_r <= 16'h0000;
      busy_cnt_r <= 16'h0000;
      gap_cnt_r <= 2'h0;
      toggle_r <= 1'b0;
      seq_err_r <= 1'b0;
      is_erase_r <= 1'b0;
      read_data_r <= `FPEC_ERASED_BYTE;
      vec_sel_r <= `FPEC_VEC_UNDEF_SWI;
      sys_reset_r <= 1'b0;
    end
    else
    begin
      sys_reset_r <= wr_lane0 && hit_s2 &&
        wbyte == `FPEC_SYS_RESET_CODE;
      if (wr_lane0 && hit_c1)
        flash_control_one_r <= wbyte;
      // Staged settings apply only on the enable code
      if (flash_code)
        cfg_r <= '{mode: stage_mode, area: stage_area,
          bank: stage_bank};
      if (wr_lane0 && hit_s3)
        system_control_three_r <= wbyte;
      if (sys_code)
        map_r <= '{ram_code: ram_bit, vec_ram: vec_bit};
      if (wr_lane0 && hit_ca)
        cmd_addr_r <= wr_data[15:0];
      if (wr_lane0 && hit_vs)
        vec_sel_r <= wbyte[2] ? `FPEC_VEC_WDT : `FPEC_VEC_UNDEF_SWI;
      if (cmd_wr && cmd_enabled)
        gap_cnt_r <= `FPEC_CMD_SPACING - 2'h1;
      else if (gap_cnt_r != 2'h0)
        gap_cnt_r <= gap_cnt_r - 2'h1;
      if (rd_data_take && is_busy)
        toggle_r <= !toggle_r;
      if (cmd_wr && cmd_enabled && cmd_too_soon)
        seq_err_r <= 1'b1;
      else if (wr_lane0 && hit_c2)
        seq_err_r <= 1'b0;
      unique case (state_r)
        fpec_pkg::FPEC_IDLE, fpec_pkg::FPEC_CMD:
        begin
          if (cmd_final_erase)
          begin
            state_r <= fpec_pkg::FPEC_BUSY;
            busy_cnt_r <= 16'(ERASE_CYCLES);
            read_data_r <= `FPEC_ERASED_BYTE;
            seq_cnt_r <= 3'h0;
          end
          else if (cmd_final_prog)
          begin
            state_r <= fpec_pkg::FPEC_BUSY;
            busy_cnt_r <= 16'(PROG_CYCLES);
            read_data_r <= read_data_r & wbyte;
            seq_cnt_r <= 3'h0;
          end
          else if (cmd_accept)
          begin
            state_r <= fpec_pkg::FPEC_CMD;
            seq_cnt_r <= seq_cnt_r + 3'h1;
            if (seq_cnt_r == `FPEC_SETUP_STEP)
              is_erase_r <= wbyte == `FPEC_SETUP_CMD;
          end
          else if (cmd_wr && cmd_enabled)
          begin
            state_r <= fpec_pkg::FPEC_IDLE;
            seq_cnt_r <= 3'h0;
          end
        end
        fpec_pkg::FPEC_BUSY:
        begin
          if (busy_cnt_r == 16'h0000)
            state_r <= fpec_pkg::FPEC_DONE;
          else
            busy_cnt_r <= busy_cnt_r - 16'h0001;
        end
        fpec_pkg::FPEC_DONE:
          state_r <= fpec_pkg::FPEC_IDLE;
      endcase
    end
  end

  // Readies are registered one edge ahead so the ports come from flops
  wire b_stays = bvalid_r && !s_axi_bready_in;
  wire awready_nxt = !wr_fire && !aw_ok && !b_stays;
  wire wready_nxt = !wr_fire && !w_ok && !b_stays;
  wire arready_nxt = !rd_take && !(rvalid_r && !s_axi_rready_in);

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      ram_code_allocate_out <= 1'b0;
      vector_in_ram_out <= 1'b0;
      flash_busy_out <= 1'b0;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      arready_r <= 1'b1;
    end
    else
    begin
      ram_code_allocate_out <= map_r.ram_code;
      vector_in_ram_out <= map_r.vec_ram;
      flash_busy_out <= is_busy;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      arready_r <= arready_nxt;
    end
  end

  assign sys_clock_reset_out = sys_reset_r;
  assign s_axi_awready_out = awready_r;
  assign s_axi_wready_out = wready_r;
  assign s_axi_bvalid_out = bvalid_r;
  assign s_axi_bresp_out = bresp_r;
  assign s_axi_arready_out = arready_r;
  assign s_axi_rvalid_out = rvalid_r;
  assign s_axi_rdata_out = rdata_r;
  assign s_axi_rresp_out = rresp_r;
endmodule : fpec_flash_ctrl

// >>> rtl/fpec_regs.svh
// Register offsets, field positions, codes and timing counts
`ifndef FPEC_REGS_SVH
`define FPEC_REGS_SVH
`define FPEC_OFF_FLASH_CTRL1 12'h000
`define FPEC_OFF_FLASH_CTRL2 12'h004
`define FPEC_OFF_SYS_CTRL2 12'h008
`define FPEC_OFF_SYS_CTRL3 12'h00C
`define FPEC_OFF_SYS_CTRL4 12'h010
`define FPEC_OFF_STATUS 12'h014
`define FPEC_OFF_CMD_ADDR 12'h018
`define FPEC_OFF_CMD_DATA 12'h01C
`define FPEC_OFF_READ_DATA 12'h020
`define FPEC_OFF_VEC_SEL 12'h024
`define FPEC_FLASH_EN_CODE 8'hD5
`define FPEC_SYS_EN_CODE 8'hD4
`define FPEC_SYS_RESET_CODE 8'h10
`define FPEC_MODE_ENABLE 3'h5
`define FPEC_MODE_DISABLE 3'h2
`define FPEC_AREA_INIT 2'h0
`define FPEC_MODE_LSB 5
`define FPEC_AREA_LSB 3
`define FPEC_BANK_BIT 2
`define FPEC_RAM_CODE_BIT 2
`define FPEC_VEC_RAM_BIT 1
`define FPEC_CMD_SPACING 2'h3
`define FPEC_CTRL1_RESET 8'h40
`define FPEC_VEC_UNDEF_SWI 16'h01F8
`define FPEC_VEC_WDT 16'h01FC
`define FPEC_ERASE_CYCLES 16'h0040
`define FPEC_PROG_CYCLES 16'h0010
`define FPEC_SECTOR_CMD 8'h30
`define FPEC_PROGRAM_CMD 8'hA0
`define FPEC_SETUP_CMD 8'h80
`define FPEC_SETUP_STEP 3'h2
`define FPEC_PROG_LAST 3'h3
`define FPEC_ERASE_LAST 3'h5
`define FPEC_ERASED_BYTE 8'hFF
`define FPEC_RESP_OKAY 2'h0
`define FPEC_RESP_SLVERR 2'h2
`endif

// >>> rtl/fpec_pkg.sv
// Types of the flash program and erase controller
package fpec_pkg;
  typedef enum logic [3:0] {
    FPEC_IDLE = 4'b0001,
    FPEC_CMD = 4'b0010,
    FPEC_BUSY = 4'b0100,
    FPEC_DONE = 4'b1000
  } fpec_state_t;

  typedef struct packed {
    logic ram_code;
    logic vec_ram;
  } fpec_map_t;

  typedef struct packed {
    logic [2:0] mode;
    logic [1:0] area;
    logic bank;
  } fpec_flash_cfg_t;
endpackage : fpec_pkg

// >>> sim/fpec_flash_ctrl_props.sv
// Port checker for the flash program and erase controller
`timescale 1ns/1ps
module fpec_flash_ctrl_props (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic ram_code_allocate_out,
  input wire logic vector_in_ram_out,
  input wire logic sys_clock_reset_out,
  input wire logic flash_busy_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);
  a_bvalid_holds: assert property (s_axi_bvalid_out && !s_axi_bready_in
    |=> s_axi_bvalid_out) else $error("bvalid dropped early");
  a_rdata_holds: assert property (s_axi_rvalid_out && !s_axi_rready_in
    |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read answer changed early");
  a_write_answer: assert property (s_axi_awvalid_in && s_axi_awready_out
    && s_axi_wvalid_in && s_axi_wready_out |=> s_axi_bvalid_out)
    else $error("write answer late");
  a_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out
    |=> s_axi_rvalid_out) else $error("read answer late");
  a_pulse_single: assert property (sys_clock_reset_out
    |=> !sys_clock_reset_out) else $error("reset pulse too long");
  a_pulse_cause: assert property (sys_clock_reset_out
    |-> s_axi_bvalid_out) else $error("reset pulse without write");
  a_ram_map_cause: assert property ($changed(ram_code_allocate_out)
    |-> $past(s_axi_bvalid_out)) else $error("ram map moved without write");
  a_vec_map_cause: assert property ($changed(vector_in_ram_out)
    |-> $past(s_axi_bvalid_out))
    else $error("vector map moved without write");
  a_busy_cause: assert property ($rose(flash_busy_out)
    |-> $past(s_axi_bvalid_out) || $past(s_axi_bvalid_out, 2))
    else $error("busy without command write");
  a_busy_ends: assert property (flash_busy_out
    |-> ##[1:200] !flash_busy_out) else $error("busy never ends");
  c_pulse: cover property (sys_clock_reset_out);
  c_ram_map: cover property ($rose(ram_code_allocate_out));
  c_busy: cover property ($rose(flash_busy_out));
endmodule : fpec_flash_ctrl_props

bind fpec_flash_ctrl fpec_flash_ctrl_props chk (.*);

// >>> sim/fpec_cpu_model.sv
// Bus master model of the processor core
`timescale 1ns/1ps
module fpec_cpu_model (
  input wire logic clk_in,
  output logic [11:0] aw_out,
  output logic awv_out,
  input wire logic awr_in,
  output logic [31:0] wd_out,
  output logic [3:0] ws_out,
  output logic wv_out,
  input wire logic wr_in,
  input wire logic [1:0] br_in,
  input wire logic bv_in,
  output logic bk_out,
  output logic [11:0] ar_out,
  output logic arv_out,
  input wire logic arr_in,
  input wire logic [31:0] rd_in,
  input wire logic [1:0] rr_in,
  input wire logic rv_in,
  output logic rk_out
);
  // Answers may be accepted a few cycles late, so held answers get tested
  initial
  begin
    {aw_out, awv_out, wd_out, wv_out, ar_out, arv_out} <= '0;
    ws_out <= 4'hF;
    bk_out <= 1'h0;
    rk_out <= 1'h0;
  end
  // One full word per write, never split
  task automatic bus_wr(input logic [11:0] a, input logic [31:0] d,
    input bit lazy, output logic [1:0] r);
    aw_out <= a;
    wd_out <= d;
    awv_out <= 1'h1;
    wv_out <= 1'h1;
    bk_out <= !lazy;
    do
    begin
      @(posedge clk_in);
      if (awv_out && awr_in) awv_out <= 1'h0;
      if (wv_out && wr_in) wv_out <= 1'h0;
      if (!bk_out) bk_out <= 1'($urandom);
    end
    while (!(bv_in && bk_out));
    r = br_in;
  endtask : bus_wr
  task automatic bus_rd(input logic [11:0] a, output logic [31:0] d,
    output logic [1:0] r);
    ar_out <= a;
    arv_out <= 1'h1;
    rk_out <= 1'h0;
    do
    begin
      @(posedge clk_in);
      if (arv_out && arr_in) arv_out <= 1'h0;
      if (!rk_out) rk_out <= 1'($urandom);
    end
    while (!(rv_in && rk_out));
    d = rd_in;
    r = rr_in;
  endtask : bus_rd
endmodule : fpec_cpu_model

// >>> sim/fpec_flash_ctrl_bench.sv
// Self-checking bench of the flash program and erase controller
`timescale 1ns/1ps
module fpec_flash_ctrl_bench;
  logic clk_in = 1'h0;
  logic rst_b_in = 1'h0;
  logic [11:0] s_axi_awaddr_in, s_axi_araddr_in;
  logic [31:0] s_axi_wdata_in, s_axi_rdata_out, d, e;
  logic [3:0] s_axi_wstrb_in;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out, r, ar;
  logic s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in;
  logic s_axi_wready_out, s_axi_bvalid_out, s_axi_bready_in;
  logic s_axi_arvalid_in, s_axi_arready_out, s_axi_rvalid_out;
  logic s_axi_rready_in, ram_code_allocate_out, vector_in_ram_out;
  logic sys_clock_reset_out, flash_busy_out;
  int fail_count = 0;
  int cmp_count = 0;
  int pulses = 0;
  logic [7:0] pv;
  logic [7:0] erase_seq [6] = '{8'hAA, 8'h55, 8'h80, 8'hAA, 8'h55, 8'h30};
  always #12.5 clk_in = ~clk_in;
  always @(posedge clk_in) if (sys_clock_reset_out) pulses++;
  // Long enough that busy outlasts the status spacing
  fpec_flash_ctrl #(.ERASE_CYCLES(40), .PROG_CYCLES(40)) dut (.*);
  fpec_cpu_model cpu (.clk_in(clk_in), .aw_out(s_axi_awaddr_in),
    .awv_out(s_axi_awvalid_in), .awr_in(s_axi_awready_out),
    .wd_out(s_axi_wdata_in), .ws_out(s_axi_wstrb_in),
    .wv_out(s_axi_wvalid_in), .wr_in(s_axi_wready_out),
    .br_in(s_axi_bresp_out), .bv_in(s_axi_bvalid_out),
    .bk_out(s_axi_bready_in), .ar_out(s_axi_araddr_in),
    .arv_out(s_axi_arvalid_in), .arr_in(s_axi_arready_out),
    .rd_in(s_axi_rdata_out), .rr_in(s_axi_rresp_out),
    .rv_in(s_axi_rvalid_out), .rk_out(s_axi_rready_in));
  function automatic logic [31:0] cfg(logic [2:0] m, logic [1:0] a);
    return {24'h00_0000, m, a, 3'h0};
  endfunction : cfg
  task automatic chk(string n, logic [31:0] x, logic [31:0] g);
    cmp_count++;
    if (g !== x)
    begin
      fail_count++;
      $display("BAD %s exp %h got %h", n, x, g);
    end
  endtask : chk
  task automatic w(logic [11:0] a, logic [31:0] v, bit lz = 1'b1);
    cpu.bus_wr(a, v, lz, r);
    chk("bresp", 32'h0, {30'h0, r});
  endtask : w
  task automatic rs(string n, logic [11:0] a, logic [31:0] m,
    logic [31:0] x);
    cpu.bus_rd(a, d, r);
    chk(n, x, d & m);
  endtask : rs
  task automatic cmd(logic [7:0] v);
    w(12'h018, 32'h0000_E000);
    w(12'h01C, {24'h00_0000, v});
    repeat (3) @(posedge clk_in);
  endtask : cmd
  task automatic poll;
    cpu.bus_rd(12'h020, d, r);
    cpu.bus_rd(12'h020, e, r);
    chk("toggle", 32'h40, (d ^ e) & 32'h40);
    chk("busyout", 32'h1, {31'h0, flash_busy_out});
    repeat (100)
    begin
      cpu.bus_rd(12'h020, d, r);
      cpu.bus_rd(12'h020, e, r);
      if (d === e) break;
    end
    rs("busy", 12'h014, 32'h1, 32'h0);
    chk("idleout", 32'h0, {31'h0, flash_busy_out});
  endtask : poll
  task automatic end_sim;
    if (fail_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim
  initial
  begin
    repeat (20000) @(posedge clk_in);
    fail_count++;
    end_sim();
  end
  initial
  begin
    void'($urandom(32'h8396));
    repeat (10) @(posedge clk_in);
    rst_b_in <= 1'h1;
    @(posedge clk_in);
    rs("ctrl1", 12'h000, 32'hFF, 32'h40);
    rs("status", 12'h014, 32'hFF_FFFF, 32'h0);
    // Vectors go to RAM before any flash write
    w(12'h00C, 32'h06);
    chk("ram", 32'h0, {31'h0, ram_code_allocate_out});
    w(12'h010, 32'hD4);
    @(posedge clk_in);
    chk("ram", 32'h1, {31'h0, ram_code_allocate_out});
    chk("vec", 32'h1, {31'h0, vector_in_ram_out});
    w(12'h024, 32'h04);
    rs("wdt", 12'h014, 32'hFF_FF00, 32'h01_FC00);
    w(12'h024, 32'h00);
    rs("swi", 12'h014, 32'hFF_FF00, 32'h01_F800);
    repeat (4)
    begin
      ar = 2'($urandom);
      pv = 8'($urandom);
      w(12'h000, cfg(3'h5, ar));
      w(12'h004, 32'hD4);
      rs("early", 12'h014, 32'hE2, 32'h0);
      w(12'h004, 32'hD5);
      rs("ctrl1", 12'h000, 32'hFF, cfg(3'h5, ar));
      rs("enabled", 12'h014, 32'h2, 32'h2);
      rs("areaon", 12'h014, 32'hE0, {24'h00_0000, ar, 6'h00});
      // Back-to-back command writes are refused and flagged
      w(12'h01C, 32'hAA, 1'b0);
      w(12'h01C, 32'h55, 1'b0);
      rs("tooclose", 12'h014, 32'h10, 32'h10);
      w(12'h004, 32'hD5);
      rs("errclr", 12'h014, 32'h10, 32'h0);
      foreach (erase_seq[i])
        cmd(erase_seq[i]);
      poll();
      rs("erased", 12'h020, 32'hFF, 32'hFF);
      cmd(8'hAA);
      cmd(8'h55);
      cmd(8'hA0);
      cmd(pv);
      poll();
      rs("progdata", 12'h020, 32'hFF, {24'h00_0000, pv});
      w(12'h000, cfg(3'h2, 2'h0));
      w(12'h004, 32'hD5);
      rs("off", 12'h014, 32'h2, 32'h0);
      rs("area", 12'h000, 32'hFF, 32'h40);
      rs("areaoff", 12'h014, 32'hE0, 32'h0);
      cmd(8'hAA);
      cmd(8'h55);
      cmd(8'hA0);
      cmd(8'h5A);
      rs("ignored", 12'h014, 32'h1, 32'h0);
      rs("unchanged", 12'h020, 32'hFF, {24'h00_0000, pv});
    end
    rs("caddr", 12'h018, 32'hFFFF, 32'hE000);
    w(12'h00C, 32'h00);
    w(12'h010, 32'hD4);
    @(posedge clk_in);
    chk("ram", 32'h0, {31'h0, ram_code_allocate_out});
    chk("vec", 32'h0, {31'h0, vector_in_ram_out});
    rs("vecoff", 12'h014, 32'hFF_FF00, 32'h0);
    w(12'h008, 32'h20);
    w(12'h008, 32'h10);
    repeat (3) @(posedge clk_in);
    chk("pulses", 32'h1, pulses);
    cpu.bus_wr(12'h100, 32'h0, 1'b1, r);
    chk("wrerr", 32'h2, {30'h0, r});
    cpu.bus_rd(12'h100, d, r);
    chk("rderr", 32'h2, {30'h0, r});
    end_sim();
  end
endmodule : fpec_flash_ctrl_bench
